// file: bpwm_top.sv
// Buffered PWM time base: period timer, duty double buffer, output pin and register port
//
// Summary of operation
// - Counter clears after matching period register
// - Pin set at rollover unless duty zero
// - Rollover copies duty buffer into active duty
// - Period is (period+1) x 4 x prescale osc
// - No postscaler in PWM timing
// - Duty is 10 bits: buffer plus low bits
// - Duty writes take effect at next match
// - Active duty register read-only in PWM
// - Active duty plus hidden latch double-buffer
// - Time base is counter plus two bits
// - Prescale 1:1 uses clock phase bits
// - Time base equal duty clears the pin
// - High time equals duty times osc times prescale
// - Counter match sets period match flag
module bpwm_top (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic PWM_OUT,
    output logic PWM_OE
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] period_register_r;
        logic [7:0] period_counter_r;
        logic [7:0] duty_write_buffer_r;
        logic [7:0] duty_active_register_r;
        logic [1:0] duty_latch_r; // hidden two-bit latch
        logic [5:0] pwm_control_register_r;
        logic [2:0] period_timer_control_r;
        logic period_match_flag_r;
        logic pin_direction_bit_r;
        logic pin_r;
        logic pin_oe_r; // registered pin driver enable
        logic [1:0] phase_r; // oscillator phase within an instruction cycle
        logic [7:0] rdata_r;
    } bpwm_state_t;

    bpwm_state_t st_r;
    bpwm_state_t st_nxt;
    logic pre_tick;
    logic [1:0] pre_fine;
    logic run;
    logic pwm_mode;
    logic instr_edge;
    logic inc;
    logic match;
    logic [9:0] time_base;
    logic [9:0] duty_active;
    logic [9:0] duty_next;
    logic [1:0] fine_bits;
    logic [1:0] phase_nxt;
    logic [7:0] count_nxt;

    assign run = st_r.period_timer_control_r[bpwm_pkg::TCTRL_RUN_BIT];
    assign pwm_mode = (st_r.pwm_control_register_r[3:0] & bpwm_pkg::MODE_PWM_MASK)
        == bpwm_pkg::MODE_PWM;
    // One instruction cycle every four oscillator phases
    assign instr_edge = run && (st_r.phase_r == 2'(bpwm_pkg::OSC_PER_INSTR - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler of the period timer, clocked by instruction cycles; no postscaler
    bpwm_prescaler u_pre (
        .clk(CLK),
        .reset_n(RESET_N),
        .run(instr_edge),
        .sel(st_r.period_timer_control_r[1:0]),
        .tick(pre_tick),
        .fine(pre_fine)
    );

    // Counter advances on each prescaled instruction cycle
    assign inc = pre_tick;
    assign match = (st_r.period_counter_r == st_r.period_register_r);

    // Phase after this edge; the time base looks one clock ahead
    assign phase_nxt = run ? (st_r.phase_r + 2'h1) : st_r.phase_r;

    // Next-cycle fine bits from clock phase at 1:1, else from prescaler
    always_comb begin
        if (st_r.period_timer_control_r[1:0] == bpwm_pkg::PRE_1) begin
            fine_bits = phase_nxt;
        end else begin
            fine_bits = pre_fine;
        end
    end

    // Counter after this edge: clearing on the next time base lets the pin
    // fall exactly duty steps after the rise instead of one clock late
    assign count_nxt = !inc ? st_r.period_counter_r
        : (match ? bpwm_pkg::ZERO8 : st_r.period_counter_r + 8'h01);
    assign time_base = {count_nxt, fine_bits};
    assign duty_active = {st_r.duty_active_register_r, st_r.duty_latch_r};
    assign duty_next = {st_r.duty_write_buffer_r,
        st_r.pwm_control_register_r[bpwm_pkg::CTRL_LOW_LSB +: 2]};

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        // Oscillator phase runs while the timer runs
        if (run) begin
            st_nxt.phase_r = st_r.phase_r + 2'h1;
        end
        // Period rollover: clear counter, reload duty, set pin, raise flag
        if (inc) begin
            if (match) begin
                st_nxt.period_counter_r = bpwm_pkg::ZERO8;
                st_nxt.duty_active_register_r = st_r.duty_write_buffer_r;
                st_nxt.duty_latch_r =
                    st_r.pwm_control_register_r[bpwm_pkg::CTRL_LOW_LSB +: 2];
                st_nxt.period_match_flag_r = 1'b1;
                if (pwm_mode) begin
                    st_nxt.pin_r = (duty_next != 10'h000);
                end
            end else begin
                st_nxt.period_counter_r = st_r.period_counter_r + 8'h01;
            end
        end
        // Duty match clears the pin; unreachable duty leaves it high all period
        if (run && pwm_mode && !(inc && match) && (time_base == duty_active)) begin
            st_nxt.pin_r = 1'b0;
        end
        if (!pwm_mode) begin
            st_nxt.pin_r = 1'b0;
        end
        // Register writes; buffer writes never touch the active duty directly
        if (WR) begin
            unique case (ADDR)
                bpwm_pkg::ADDR_PERIOD: st_nxt.period_register_r = WDATA;
                bpwm_pkg::ADDR_COUNTER: st_nxt.period_counter_r = WDATA;
                bpwm_pkg::ADDR_DUTY_BUF: st_nxt.duty_write_buffer_r = WDATA;
                bpwm_pkg::ADDR_DUTY_ACT: begin
                    if (!pwm_mode) begin
                        st_nxt.duty_active_register_r = WDATA;
                    end
                end
                bpwm_pkg::ADDR_PWM_CTRL: st_nxt.pwm_control_register_r = WDATA[5:0];
                bpwm_pkg::ADDR_TMR_CTRL: st_nxt.period_timer_control_r = WDATA[2:0];
                bpwm_pkg::ADDR_FLAGS: begin
                    // Set wins over a clear in the same cycle
                    if (!WDATA[bpwm_pkg::FLAG_MATCH_BIT] && !(inc && match)) begin
                        st_nxt.period_match_flag_r = 1'b0;
                    end
                end
                bpwm_pkg::ADDR_PIN_DIR: st_nxt.pin_direction_bit_r = WDATA[0];
            endcase
        end
        // Driver enable kept in a flip-flop of its own, inverse of the direction bit
        st_nxt.pin_oe_r = !st_nxt.pin_direction_bit_r;
        // Read data, valid in the cycle after the strobe only
        st_nxt.rdata_r = 8'h00;
        if (RD) begin
            unique case (ADDR)
                bpwm_pkg::ADDR_PERIOD: st_nxt.rdata_r = st_r.period_register_r;
                bpwm_pkg::ADDR_COUNTER: st_nxt.rdata_r = st_r.period_counter_r;
                bpwm_pkg::ADDR_DUTY_BUF: st_nxt.rdata_r = st_r.duty_write_buffer_r;
                bpwm_pkg::ADDR_DUTY_ACT: st_nxt.rdata_r = st_r.duty_active_register_r;
                bpwm_pkg::ADDR_PWM_CTRL: st_nxt.rdata_r = {2'h0, st_r.pwm_control_register_r};
                bpwm_pkg::ADDR_TMR_CTRL: st_nxt.rdata_r = {5'h00, st_r.period_timer_control_r};
                bpwm_pkg::ADDR_FLAGS: st_nxt.rdata_r = {6'h00, st_r.period_match_flag_r, 1'b0};
                bpwm_pkg::ADDR_PIN_DIR: st_nxt.rdata_r = {7'h00, st_r.pin_direction_bit_r};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= '0;
            st_r.period_register_r <= bpwm_pkg::PERIOD_RST;
            st_r.pin_direction_bit_r <= bpwm_pkg::PIN_DIR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA = st_r.rdata_r;
    assign PWM_OUT = st_r.pin_r;
    assign PWM_OE = st_r.pin_oe_r; // Driver on when direction bit clear
endmodule

// file: bpwm_pkg.sv
// Package with register map, field positions, reset values and timing constants of the PWM block
package bpwm_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_PERIOD = 3'h0; // period_register
    localparam logic [2:0] ADDR_COUNTER = 3'h1; // period_counter
    localparam logic [2:0] ADDR_DUTY_BUF = 3'h2; // duty_write_buffer
    localparam logic [2:0] ADDR_DUTY_ACT = 3'h3; // duty_active_register
    localparam logic [2:0] ADDR_PWM_CTRL = 3'h4; // pwm_control_register
    localparam logic [2:0] ADDR_TMR_CTRL = 3'h5; // period_timer_control
    localparam logic [2:0] ADDR_FLAGS = 3'h6; // peripheral_flag_register
    localparam logic [2:0] ADDR_PIN_DIR = 3'h7; // pin_direction_bit
    // pwm_control_register fields
    localparam int CTRL_LOW_LSB = 4; // duty_low_bits at [5:4]
    localparam int CTRL_MODE_LSB = 0; // mode at [3:0]
    localparam logic [3:0] MODE_PWM = 4'hC; // Any code 11xx selects PWM
    localparam logic [3:0] MODE_PWM_MASK = 4'hC;
    // period_timer_control fields
    localparam int TCTRL_RUN_BIT = 2; // timer_run_bit
    localparam int TCTRL_PRE_LSB = 0; // prescale_select at [1:0]
    // peripheral_flag_register fields
    localparam int FLAG_MATCH_BIT = 1; // period_match_flag
    // Reset values
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic PIN_DIR_RST = 1'b1; // Driver off after reset
    // Prescale select codes
    localparam logic [1:0] PRE_1 = 2'h0;
    localparam logic [1:0] PRE_4 = 2'h1;
    // Oscillator clocks per instruction cycle
    localparam int OSC_PER_INSTR = 4;
endpackage

// file: bpwm_prescaler.sv
// Prescaler for the period counter, also supplying the two fine time-base bits
module bpwm_prescaler (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic tick,
    output logic [1:0] fine
);
    typedef struct packed {
        logic [5:0] cnt_r;
    } bpwm_pre_state_t;

    bpwm_pre_state_t st_r;
    bpwm_pre_state_t st_nxt;
    logic [5:0] limit;

    ////////////////////////////////////////////////////////////////////////////
    // Terminal count per selection: 1, 4, 16, 64 instruction-cycle steps
    always_comb begin
        unique case (sel)
            2'h0: limit = 6'h00;
            2'h1: limit = 6'h03;
            2'h2: limit = 6'h0F;
            2'h3: limit = 6'h3F;
        endcase
    end

    // Count only while running; holds still otherwise
    always_comb begin
        st_nxt = st_r;
        tick = 1'b0;
        if (run) begin
            if (st_r.cnt_r >= limit) begin
                st_nxt.cnt_r = 6'h00;
                tick = 1'b1;
            end else begin
                st_nxt.cnt_r = st_r.cnt_r + 6'h01;
            end
        end
    end

    // Top two bits of the next prescale count, so the time base looks one clock ahead
    always_comb begin
        unique case (sel)
            2'h0: fine = 2'h0;
            2'h1: fine = st_nxt.cnt_r[1:0];
            2'h2: fine = st_nxt.cnt_r[3:2];
            2'h3: fine = st_nxt.cnt_r[5:4];
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// file: bpwm_monitor.sv
// Checker on the PWM block ports, bound into the top module
module bpwm_monitor (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic PWM_OUT,
    input wire logic PWM_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] per_s, buf_s, ctl_s;
    logic [1:0] pre_s;
    logic run_s, p_r, v_r, rise, fall;
    int c_r, q_r, pv, dut;
    // Prescale factor, programmed duty and pin edges
    assign pv = 1 << (2 * pre_s);
    assign dut = int'({buf_s, ctl_s[5:4]});
    assign rise = PWM_OUT && !p_r;
    assign fall = !PWM_OUT && p_r;
    // Shadow registers; rise-based spans are trusted only after 3 write-free cycles
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            per_s <= 8'hFF;
            {buf_s, ctl_s, run_s, pre_s, p_r, v_r} <= '0;
            c_r <= 0;
            q_r <= 0;
        end else begin
            if (WR && ADDR == bpwm_pkg::ADDR_PERIOD) per_s <= WDATA;
            if (WR && ADDR == bpwm_pkg::ADDR_DUTY_BUF) buf_s <= WDATA;
            if (WR && ADDR == bpwm_pkg::ADDR_PWM_CTRL) ctl_s <= WDATA;
            if (WR && ADDR == bpwm_pkg::ADDR_TMR_CTRL) {run_s, pre_s} <= WDATA[2:0];
            p_r <= PWM_OUT;
            c_r <= rise ? 1 : c_r + 1;
            q_r <= WR ? 0 : (q_r > 2 ? 3 : q_r + 1);
            v_r <= WR ? 1'b0 : (rise ? (q_r > 2) : v_r);
        end
    end
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    period_span_a: assert property (rise && v_r |-> c_r == (per_s + 1) * 4 * pv)
        else $error("pwm period length wrong");
    high_width_a: assert property (fall && v_r |-> c_r == dut * pv)
        else $error("pwm high time wrong");
    zero_duty_a: assert property (rise && q_r > 2 |-> dut != 0)
        else $error("pin set with zero duty");
    run_hold_a: assert property (!run_s && ctl_s[3:2] == 2'b11 |=> $stable(PWM_OUT))
        else $error("pin moved while stopped");
    mode_low_a: assert property (ctl_s[3:2] != 2'b11 |=> !PWM_OUT)
        else $error("pin high outside pwm mode");
    oe_follow_a: assert property (WR && ADDR == bpwm_pkg::ADDR_PIN_DIR
        |-> ##2 PWM_OE == !$past(WDATA[0], 2))
        else $error("driver enable wrong");
    per_read_a: assert property (RD && ADDR == bpwm_pkg::ADDR_PERIOD |=> RDATA == per_s)
        else $error("period readback wrong");
    buf_read_a: assert property (RD && ADDR == bpwm_pkg::ADDR_DUTY_BUF |=> RDATA == buf_s)
        else $error("duty buffer readback wrong");
endmodule
bind bpwm_top bpwm_monitor bpwm_monitor_inst (
    .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE)
);

// file: bpwm_load.sv
// Load on the pwm pin: counts cycles it is driven high
module bpwm_load (
    input wire logic clk,
    input wire logic pin,
    input wire logic oe,
    output int hi_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    initial hi_cnt = 0;
    // A released pin drives nothing into the load
    always @(posedge clk) if (oe === 1'b1 && pin === 1'b1) hi_cnt <= hi_cnt + 1;
endmodule

// file: tb.sv
// Self-checking testbench for the buffered PWM block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA, rv;
    logic PWM_OUT, PWM_OE;
    int hi_cnt, per, failures = 0, samples_checked = 0;
    logic [7:0] rst_q[$] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    bpwm_top bpwm_top_inst (
        .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE)
    );
    bpwm_load bpwm_load_inst (.clk(CLK), .pin(PWM_OUT), .oe(PWM_OE), .hi_cnt(hi_cnt));
    // Clock
    always #5 CLK = ~CLK;
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Register bus cycles; a gap cycle keeps strobes single
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [2:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        rv = RDATA;
        @(posedge CLK);
    endtask
    // Stop, load a new duty, restart with prescale code pc, count high cycles
    task automatic run_case(input int pc, input int d);
        int pv, h0, reach;
        pv = 1 << (2 * pc);
        reach = (per + 1) * 4;
        wr(bpwm_pkg::ADDR_TMR_CTRL, 8'h00);
        rd(bpwm_pkg::ADDR_COUNTER);
        h0 = rv;
        rd(bpwm_pkg::ADDR_COUNTER);
        chk(rv, h0);
        rd(bpwm_pkg::ADDR_DUTY_ACT);
        h0 = rv;
        wr(bpwm_pkg::ADDR_DUTY_BUF, d[9:2]);
        wr(bpwm_pkg::ADDR_PWM_CTRL, {2'b00, d[1:0], bpwm_pkg::MODE_PWM});
        wr(bpwm_pkg::ADDR_DUTY_ACT, ~h0[7:0]);
        rd(bpwm_pkg::ADDR_DUTY_ACT);
        chk(rv, h0);
        wr(bpwm_pkg::ADDR_TMR_CTRL, {5'h00, 1'b1, pc[1:0]});
        repeat (2 * reach * pv) @(posedge CLK);
        h0 = hi_cnt;
        repeat (4 * reach * pv) @(posedge CLK);
        chk(hi_cnt - h0, 4 * pv * (d < reach ? d : reach));
        rd(bpwm_pkg::ADDR_DUTY_ACT);
        chk(rv, d[9:2]);
    endtask
    ////////////////////////////////////////
    // Reset, setup sequence, then duty and prescale cases
    initial begin
        void'($urandom(32'h5BCB8F2D));
        per = $urandom_range(2, 6);
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        foreach (rst_q[i]) begin
            rd(3'(i));
            chk(rv, rst_q[i]);
        end
        chk({PWM_OUT, PWM_OE}, 2'b00);
        wr(bpwm_pkg::ADDR_PIN_DIR, 8'h01);
        wr(bpwm_pkg::ADDR_PERIOD, 8'(per));
        wr(bpwm_pkg::ADDR_PWM_CTRL, {4'h0, bpwm_pkg::MODE_PWM});
        wr(bpwm_pkg::ADDR_FLAGS, 8'h00);
        rd(bpwm_pkg::ADDR_FLAGS);
        chk(rv[1], 1'b0);
        wr(bpwm_pkg::ADDR_TMR_CTRL, 8'h04);
        for (int i = 0; i < 300 && rv[1] !== 1'b1; i++) rd(bpwm_pkg::ADDR_FLAGS);
        chk(rv[1], 1'b1);
        if (rv[1] === 1'b1) begin
            wr(bpwm_pkg::ADDR_PIN_DIR, 8'h00);
            for (int p = 0; p < 4; p++) run_case(p, $urandom_range(1, (per + 1) * 4 - 1));
            run_case(0, 0);
            run_case(0, (per + 1) * 4);
            run_case(1, 1023);
            chk(PWM_OE, 1'b1);
        end
        end_sim();
    end
endmodule
